// file: logic/watchdog_interval_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Period code 0..6 gives 2^12..2^18 cycles, code 7 gives 2^20.
// - Period register takes byte writes only, resets to zero, upper bits read zero.
// - Mode register takes bit and byte writes; mode bits 4,3; restart bit 7.
// - Bit 4 low: interval interrupt; high: bit 3 picks NMI or chip reset.
// - Mode bits, once one, ignore software zeros until system reset.
// - Restart bit cannot be cleared; only reset stops a started counter.
// - Writing one to restart clears and starts counting; zero leaves stopped counter stopped.
// - Missed restart in watchdog mode gives reset or NMI per bit 3.
// - First period after restart may be up to half a percent short.
// - Counting continues in HALT, freezes in STOP.
// - Counting halts while the CPU runs from the subsystem clock.
// - Interval mode raises a maskable request at every overflow, no restart needed.
// - Interval request obeys its mask and priority flags; highest default priority.
module watchdog_interval_timer #(
    parameter int BASE_EXP = wdt_pkg::PERIOD_BASE_EXP,
    parameter int CODE7_EXP = wdt_pkg::PERIOD_CODE7_EXP
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // CPU data bus
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr_byte,
    input wire logic bus_wr_bit,
    input wire logic [2:0] bus_bit_pos,
    input wire logic bus_bit_val,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    // CPU operating state
    input wire logic cpu_stop,
    input wire logic cpu_subclock,
    // Interrupt controller flags
    input wire logic interval_irq_mask,
    input wire logic interval_irq_priority,
    // Requests
    output logic interval_irq,
    output logic interval_irq_prio,
    output logic nmi_req,
    output logic chip_reset_req
);

    // Register state
    logic [wdt_pkg::PERIOD_CODE_WIDTH-1:0] period_code;
    logic [wdt_pkg::PERIOD_CODE_WIDTH-1:0] next_period_code;
    logic watchdog_mode_select;
    logic next_watchdog_mode_select;
    logic overflow_action_select;
    logic next_overflow_action_select;
    logic run;
    logic next_run;
    logic [7:0] next_bus_rdata;

    // Request state
    logic next_interval_irq;
    logic next_interval_irq_prio;
    logic next_nmi_req;
    logic next_chip_reset_req;

    // Decode
    logic sel_period;
    logic sel_mode;
    logic mode_byte_wr;
    logic mode_bit_wr;
    logic restart_req;
    logic set_watchdog_mode;
    logic set_overflow_action;
    logic overflow;

    wdt_cnt_if cnt_bus ();

    assign sel_period = (bus_addr == wdt_pkg::ADDR_PERIOD_SELECT);
    assign sel_mode = (bus_addr == wdt_pkg::ADDR_MODE_CONTROL);
    assign mode_byte_wr = bus_wr_byte && sel_mode;
    assign mode_bit_wr = bus_wr_bit && sel_mode;

    // Only writes of one matter: a zero never clears a sticky bit
    assign restart_req = (mode_byte_wr && bus_wdata[wdt_pkg::BIT_RESTART]) ||
        (mode_bit_wr && bus_bit_pos == wdt_pkg::BIT_RESTART && bus_bit_val);
    assign set_watchdog_mode = (mode_byte_wr && bus_wdata[wdt_pkg::BIT_WATCHDOG_MODE]) ||
        (mode_bit_wr && bus_bit_pos == wdt_pkg::BIT_WATCHDOG_MODE && bus_bit_val);
    assign set_overflow_action = (mode_byte_wr && bus_wdata[wdt_pkg::BIT_OVERFLOW_ACTION]) ||
        (mode_bit_wr && bus_bit_pos == wdt_pkg::BIT_OVERFLOW_ACTION && bus_bit_val);

    // Register file
    always_comb begin
        next_period_code = period_code;
        // Bit writes to the period register are dropped; it is a byte-only register
        if (bus_wr_byte && sel_period) begin
            next_period_code = bus_wdata[wdt_pkg::PERIOD_CODE_WIDTH-1:0];
        end
        next_watchdog_mode_select = watchdog_mode_select || set_watchdog_mode;
        next_overflow_action_select = overflow_action_select || set_overflow_action;
        next_run = run || restart_req;
        next_bus_rdata = bus_rdata;
        if (bus_rd) begin
            if (sel_period) begin
                next_bus_rdata = {5'h00, period_code};
            end else if (sel_mode) begin
                next_bus_rdata = {run, 2'h0, watchdog_mode_select, overflow_action_select, 3'h0};
            end else begin
                next_bus_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            period_code <= wdt_pkg::PERIOD_SELECT_RESET[wdt_pkg::PERIOD_CODE_WIDTH-1:0];
            watchdog_mode_select <= wdt_pkg::MODE_CONTROL_RESET[wdt_pkg::BIT_WATCHDOG_MODE];
            overflow_action_select <= wdt_pkg::MODE_CONTROL_RESET[wdt_pkg::BIT_OVERFLOW_ACTION];
            run <= wdt_pkg::MODE_CONTROL_RESET[wdt_pkg::BIT_RESTART];
            bus_rdata <= 8'h00;
        end else begin
            period_code <= next_period_code;
            watchdog_mode_select <= next_watchdog_mode_select;
            overflow_action_select <= next_overflow_action_select;
            run <= next_run;
            bus_rdata <= next_bus_rdata;
        end
    end

    // Counter; HALT needs no input because it does not stop counting
    assign cnt_bus.count_en = run && !cpu_stop && !cpu_subclock;
    assign cnt_bus.restart = restart_req;
    assign cnt_bus.period_code = period_code;
    assign overflow = cnt_bus.overflow;

    wdt_counter #(
        .BASE_EXP(BASE_EXP),
        .CODE7_EXP(CODE7_EXP)
    ) u_counter (
        .sys_clk(sys_clk),
        .reset(reset),
        .cnt_port(cnt_bus.counter)
    );

    // Overflow dispatch; the mode in force at the overflow decides the action
    always_comb begin
        next_interval_irq = overflow && !watchdog_mode_select && !interval_irq_mask;
        next_nmi_req = overflow && watchdog_mode_select && !overflow_action_select;
        next_chip_reset_req = overflow && watchdog_mode_select && overflow_action_select;
        next_interval_irq_prio = interval_irq_priority;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            interval_irq <= 1'b0;
            nmi_req <= 1'b0;
            chip_reset_req <= 1'b0;
            interval_irq_prio <= 1'b0;
        end else begin
            interval_irq <= next_interval_irq;
            nmi_req <= next_nmi_req;
            chip_reset_req <= next_chip_reset_req;
            interval_irq_prio <= next_interval_irq_prio;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_overflow_nmi;
        overflow && watchdog_mode_select && !overflow_action_select;
    endsequence

    sequence s_overflow_reset;
        overflow && watchdog_mode_select && overflow_action_select;
    endsequence

    sequence s_overflow_interval;
        overflow && !watchdog_mode_select;
    endsequence

    sequence s_period_read;
        bus_rd && sel_period;
    endsequence

    a_period_readback: assert property (
        s_period_read |=> bus_rdata == {5'h00, $past(period_code)})
        else $error("period register read wrong or upper bits not zero");

    a_period_bit_ignored: assert property (
        bus_wr_bit && !bus_wr_byte |=> $stable(period_code))
        else $error("bit write changed the period register");

    a_period_byte_write: assert property (
        bus_wr_byte && sel_period |=> period_code == $past(bus_wdata[2:0]))
        else $error("byte write did not load the period code");

    a_mode_sticky: assert property (
        watchdog_mode_select |=> watchdog_mode_select [*8])
        else $error("watchdog mode bit returned to zero");

    a_action_sticky: assert property (
        $past(overflow_action_select) |-> overflow_action_select)
        else $error("overflow action bit returned to zero");

    a_run_sticky: assert property (
        run |=> run)
        else $error("restart bit cleared after counting started");

    a_stopped_stays: assert property (
        !run && !restart_req |=> !run && !overflow)
        else $error("counter started without a restart write");

    a_restart_starts: assert property (
        restart_req |=> run && !overflow)
        else $error("restart write did not start counting");

    a_nmi_on_overflow: assert property (
        s_overflow_nmi |=> nmi_req && !chip_reset_req && !interval_irq)
        else $error("watchdog mode 1 overflow did not raise the NMI");

    a_reset_on_overflow: assert property (
        s_overflow_reset |=> chip_reset_req && !nmi_req && !interval_irq)
        else $error("watchdog mode 2 overflow did not request reset");

    a_interval_request: assert property (
        s_overflow_interval |=> interval_irq == !$past(interval_irq_mask) && !nmi_req && !chip_reset_req)
        else $error("interval overflow request wrong");

    a_requests_quiet: assert property (
        !overflow |=> !interval_irq && !nmi_req && !chip_reset_req)
        else $error("request without an overflow");

    a_stop_freezes: assert property (
        cpu_stop && !restart_req |=> !overflow)
        else $error("overflow while the CPU is stopped");

    a_subclock_halts: assert property (
        cpu_subclock && !restart_req |=> !overflow)
        else $error("overflow while running from the subsystem clock");

endmodule // watchdog_interval_timer

// file: common/wdt_pkg.sv
package wdt_pkg;

    // Register map, byte wide registers on the CPU data bus
    localparam logic [15:0] ADDR_PERIOD_SELECT = 16'hFF42;
    localparam logic [15:0] ADDR_MODE_CONTROL = 16'hFFF9;

    // Reset values
    localparam logic [7:0] PERIOD_SELECT_RESET = 8'h00;
    localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;

    // Field layout of the period select register
    localparam int PERIOD_CODE_WIDTH = 3;
    localparam logic [2:0] PERIOD_CODE_LONGEST = 3'h7;

    // Field layout of the mode control register
    localparam logic [2:0] BIT_RESTART = 3'h7;
    localparam logic [2:0] BIT_WATCHDOG_MODE = 3'h4;
    localparam logic [2:0] BIT_OVERFLOW_ACTION = 3'h3;

    // Counter structure and overflow exponents, in main clock cycles as powers of two
    localparam int COUNT_WIDTH = 20;
    localparam int PRESCALE_BITS = 4;
    localparam int EXP_WIDTH = 6;
    localparam int PERIOD_BASE_EXP = 12;
    localparam int PERIOD_CODE7_EXP = 20;

endpackage

// file: common/wdt_cnt_if.sv
`timescale 1ns/1ps
interface wdt_cnt_if;
    logic count_en;
    logic restart;
    logic [wdt_pkg::PERIOD_CODE_WIDTH-1:0] period_code;
    logic overflow;

    modport ctrl (
        output count_en,
        output restart,
        output period_code,
        input overflow
    );

    modport counter (
        input count_en,
        input restart,
        input period_code,
        output overflow
    );
endinterface // wdt_cnt_if

// file: logic/wdt_counter.sv
`timescale 1ns/1ps
module wdt_counter #(
    parameter int BASE_EXP = wdt_pkg::PERIOD_BASE_EXP,
    parameter int CODE7_EXP = wdt_pkg::PERIOD_CODE7_EXP
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Control side
    wdt_cnt_if.counter cnt_port
);

    logic [wdt_pkg::COUNT_WIDTH-1:0] count;
    logic [wdt_pkg::COUNT_WIDTH-1:0] next_count;
    logic [wdt_pkg::COUNT_WIDTH-1:0] span_mask;
    logic [wdt_pkg::EXP_WIDTH-1:0] sel_exp;
    logic overflow;
    logic next_overflow;
    logic at_limit;

    assign sel_exp = (cnt_port.period_code == wdt_pkg::PERIOD_CODE_LONGEST) ?
        wdt_pkg::EXP_WIDTH'(CODE7_EXP) :
        wdt_pkg::EXP_WIDTH'(BASE_EXP) + wdt_pkg::EXP_WIDTH'(cnt_port.period_code);

    genvar i;
    generate
        for (i = 0; i < wdt_pkg::COUNT_WIDTH; i++) begin : g_span
            assign span_mask[i] = (wdt_pkg::EXP_WIDTH'(i) < sel_exp);
        end
    endgenerate

    // Selected stage is about to toggle back to zero
    assign at_limit = &(count | ~span_mask);

    always_comb begin
        next_count = count;
        next_overflow = 1'b0;
        if (cnt_port.count_en) begin
            next_count = count + 20'h00001;
            next_overflow = at_limit && !cnt_port.restart;
        end
        // Low prescaler stages keep running, so the first period may come short
        if (cnt_port.restart) begin
            next_count[wdt_pkg::COUNT_WIDTH-1:wdt_pkg::PRESCALE_BITS] = '0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count <= '0;
            overflow <= 1'b0;
        end else begin
            count <= next_count;
            overflow <= next_overflow;
        end
    end

    assign cnt_port.overflow = overflow;

    a_restart_clears: assert property (@(posedge sys_clk) disable iff (reset)
        cnt_port.restart |=> count[wdt_pkg::COUNT_WIDTH-1:wdt_pkg::PRESCALE_BITS] == '0)
        else $error("restart did not clear the counter");

    a_count_freeze: assert property (@(posedge sys_clk) disable iff (reset)
        !cnt_port.count_en && !cnt_port.restart |=> $stable(count) && !overflow)
        else $error("counter moved while counting is stopped");

    a_overflow_single: assert property (@(posedge sys_clk) disable iff (reset)
        overflow |=> !overflow)
        else $error("overflow pulse longer than one cycle");

    a_overflow_cause: assert property (@(posedge sys_clk) disable iff (reset)
        overflow |-> $past(at_limit) && $past(cnt_port.count_en) && ~|(count & $past(span_mask)))
        else $error("overflow without selected stage wrapping");

endmodule // wdt_counter

// file: sim/cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
    // Clock
    input wire logic sys_clk,
    // Data bus towards the timer
    output logic [15:0] bus_addr,
    output logic [7:0] bus_wdata,
    output logic bus_wr_byte,
    output logic bus_wr_bit,
    output logic [2:0] bus_bit_pos,
    output logic bus_bit_val,
    output logic bus_rd,
    // Operating state
    output logic cpu_stop,
    output logic cpu_subclock
);
    initial begin
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
        bus_wr_byte = 1'b0;
        bus_wr_bit = 1'b0;
        bus_bit_pos = 3'h0;
        bus_bit_val = 1'b0;
        bus_rd = 1'b0;
        cpu_stop = 1'b0;
        cpu_subclock = 1'b0;
    end

    // Released fields are inverted so a stale value never looks like a held request
    task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr_byte <= 1'b1;
        @(posedge sys_clk);
        bus_wr_byte <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~d;
    endtask

    task automatic wr_bit(input logic [15:0] a, input logic [2:0] p, input logic v);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_bit_pos <= p;
        bus_bit_val <= v;
        bus_wr_bit <= 1'b1;
        @(posedge sys_clk);
        bus_wr_bit <= 1'b0;
        bus_addr <= ~a;
        bus_bit_pos <= ~p;
        bus_bit_val <= ~v;
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        bus_addr <= ~a;
    endtask

    // Standby needs no restart; the caller restarts before the STOP hold but not before the subclock hold
    task automatic hold(input logic stop, input logic sub, input int n);
        @(posedge sys_clk);
        cpu_stop <= stop;
        cpu_subclock <= sub;
        repeat (n) @(posedge sys_clk);
        cpu_stop <= 1'b0;
        cpu_subclock <= 1'b0;
    endtask
endmodule // cpu_model

// file: sim/test_watchdog_interval_timer.sv
`timescale 1ns/1ps
module test_watchdog_interval_timer;
    localparam int BASE = 5;
    localparam int TOP = 13;
    localparam logic [15:0] PS = wdt_pkg::ADDR_PERIOD_SELECT;
    localparam logic [15:0] MC = wdt_pkg::ADDR_MODE_CONTROL;
    typedef struct {int kind; int lo; int hi; logic [7:0] val;} note_t;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic irq_mask = 1'b0;
    logic irq_prio = 1'b0;
    logic [15:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr_byte, bus_wr_bit, bus_bit_val, bus_rd, cpu_stop, cpu_subclock;
    logic [2:0] bus_bit_pos;
    logic [7:0] bus_rdata;
    logic interval_irq, interval_irq_prio, nmi_req, chip_reset_req;
    note_t notes[$];
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    int ref_cyc = 0;
    int seed = 31658;
    int p;
    logic rd_d = 1'b0;
    logic prio_d = 1'b0;

    always #2 sys_clk = ~sys_clk;
    always @(negedge sys_clk) cyc++;
    always @(posedge sys_clk) irq_prio <= 1'($random(seed));

    cpu_model cpu_model_inst (.sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr_byte(bus_wr_byte), .bus_wr_bit(bus_wr_bit), .bus_bit_pos(bus_bit_pos),
        .bus_bit_val(bus_bit_val), .bus_rd(bus_rd), .cpu_stop(cpu_stop), .cpu_subclock(cpu_subclock));

    watchdog_interval_timer #(.BASE_EXP(BASE), .CODE7_EXP(TOP)) watchdog_interval_timer_inst (
        .sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr_byte(bus_wr_byte), .bus_wr_bit(bus_wr_bit), .bus_bit_pos(bus_bit_pos),
        .bus_bit_val(bus_bit_val), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cpu_stop(cpu_stop),
        .cpu_subclock(cpu_subclock), .interval_irq_mask(irq_mask), .interval_irq_priority(irq_prio),
        .interval_irq(interval_irq), .interval_irq_prio(interval_irq_prio), .nmi_req(nmi_req),
        .chip_reset_req(chip_reset_req));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Results are matched in order, so reads are only issued while no request is due
    always @(posedge sys_clk) begin : monitor
        note_t n;
        int k;
        k = interval_irq ? 1 : nmi_req ? 2 : chip_reset_req ? 3 : 0;
        if (!reset && (rd_d || k != 0)) begin
            if (notes.size() == 0) begin
                check(8'(k), 8'h00, "unexpected request");
            end else begin
                n = notes.pop_front();
                check(8'(k), 8'(n.kind), "result kind");
                if (rd_d) begin
                    check(bus_rdata, n.val, "read data");
                end else begin
                    check(8'((cyc - ref_cyc) >= n.lo && (cyc - ref_cyc) <= n.hi), 8'h01, "timing");
                    ref_cyc = cyc;
                end
            end
        end
        if (!reset && interval_irq) begin
            check(8'(interval_irq_prio), 8'(prio_d), "priority flag");
        end
        rd_d = bus_rd;
        prio_d = irq_prio;
    end

    task automatic expect_read(input logic [15:0] a, input logic [7:0] v);
        notes.push_back('{0, 0, 0, v});
        cpu_model_inst.rd(a);
    endtask

    task automatic expect_req(input int kind, input int lo, input int hi);
        notes.push_back('{kind, lo, hi, 8'h00});
    endtask

    task automatic start(input logic [7:0] mode);
        cpu_model_inst.wr_byte(MC, mode);
        ref_cyc = cyc;
    endtask

    task automatic finish_test(input string name, input int limit);
        int n;
        n = 0;
        while (notes.size() != 0 && n < limit) begin
            @(posedge sys_clk);
            n++;
        end
        check(8'(notes.size()), 8'h00, "pending results");
        $display("test %s done", name);
    endtask

    task automatic pulse_reset;
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        expect_read(PS, 8'h00);
        expect_read(MC, 8'h00);
        expect_read(16'hFF40, 8'h00);
        cpu_model_inst.wr_byte(PS, {5'($random(seed)), 3'h5});
        expect_read(PS, 8'h05);
        cpu_model_inst.wr_bit(PS, 3'h0, 1'b0);
        expect_read(PS, 8'h05);
        finish_test("reset_and_period_reg", 10);
        cpu_model_inst.wr_bit(MC, 3'h3, 1'b1);
        expect_read(MC, 8'h08);
        cpu_model_inst.wr_bit(MC, 3'h3, 1'b0);
        cpu_model_inst.wr_bit(MC, 3'h5, 1'b1);
        cpu_model_inst.wr_byte(MC, 8'h00);
        expect_read(MC, 8'h08);
        repeat (100) @(posedge sys_clk);
        finish_test("mode_reg_sticky", 10);
        for (int code = 0; code < 8; code++) begin
            pulse_reset();
            p = (code == 7) ? (1 << TOP) : (1 << (BASE + code));
            cpu_model_inst.wr_byte(PS, 8'(code));
            expect_req(1, p - 16, p + 4);
            expect_req(1, p, p);
            expect_req(1, p, p);
            start(8'h80);
            finish_test("interval_period", 3 * p + 50);
        end
        pulse_reset();
        p = 1 << BASE;
        expect_req(1, p - 16, p + 4);
        start(8'h80);
        finish_test("interval_first", 2 * p);
        irq_mask <= 1'b1;
        expect_req(1, 2 * p, 2 * p);
        repeat (p + 10) @(posedge sys_clk);
        irq_mask <= 1'b0;
        finish_test("interval_mask", 3 * p);
        expect_req(1, p + 100 - 16, p + 104);
        start(8'h80);
        cpu_model_inst.hold(1'b1, 1'b0, 100);
        finish_test("stop_freeze", 3 * p);
        expect_req(1, p + 50, p + 50);
        cpu_model_inst.hold(1'b0, 1'b1, 50);
        finish_test("subclock_freeze", 3 * p);
        pulse_reset();
        p = 1 << (BASE + 1);
        cpu_model_inst.wr_byte(PS, 8'h01);
        start(8'h90);
        expect_read(MC, 8'h90);
        cpu_model_inst.wr_byte(MC, 8'h00);
        expect_read(MC, 8'h90);
        repeat (4) begin
            repeat (p - 20) @(posedge sys_clk);
            start(8'h90);
        end
        expect_req(2, p - 16, p + 4);
        expect_req(2, p, p);
        finish_test("watchdog_nmi", 3 * p);
        pulse_reset();
        p = 1 << BASE;
        cpu_model_inst.wr_bit(MC, 3'h4, 1'b1);
        cpu_model_inst.wr_bit(MC, 3'h3, 1'b1);
        expect_req(3, p - 16, p + 4);
        cpu_model_inst.wr_bit(MC, 3'h7, 1'b1);
        ref_cyc = cyc;
        finish_test("watchdog_reset", 2 * p);
        print_verdict();
    end

    initial begin
        #400000;
        fails++;
        $display("[ERR] %0t run did not finish in time", $time);
        print_verdict();
    end
endmodule // test_watchdog_interval_timer
